// File: ppu_defines.svh
// Purpose: offsets, field layout, reset values and widths of the pullup enable block
// Assumes: classic wishbone slave with 32-bit data, byte addresses on a 16-bit bus
// Notes: every register is one aligned word; 8-bit data sits in bits 7:0
`ifndef PPU_DEFINES_SVH
`define PPU_DEFINES_SVH

// bus geometry
`define PPU_ADR_W 16
`define PPU_DAT_W 32
`define PPU_SEL_W 4
`define PPU_REG_W 8

// pins per port: port e has eight, port d three pullup-capable pins
`define PPU_PE_W 8
`define PPU_PD_W 3

// byte addresses of the register words
`define PPU_PE_PULL_ADR 16'h30f4
`define PPU_PD_PULL_ADR 16'h30f0
`define PPU_PE_DOUT_ADR 16'h30e0
`define PPU_PE_DIR_ADR 16'h30e4
`define PPU_PE_INOFF_ADR 16'h30e8
`define PPU_PE_LEVEL_ADR 16'h30ec
`define PPU_PD_DOUT_ADR 16'h30d0
`define PPU_PD_DIR_ADR 16'h30d4
`define PPU_PD_INOFF_ADR 16'h30d8
`define PPU_PD_LEVEL_ADR 16'h30dc

// reset values: high-impedance inputs, pullups off
`define PPU_PE_RST 8'h00
`define PPU_PD_RST 3'h0

// byte lane that carries the register data
`define PPU_DATA_LANE 0

`endif

// File: ppu_pad_model.sv
// Purpose: board side of one port, making the pad levels the block sees
// Assumes: nothing outside drives the pins
// Notes: a pin nobody holds toggles every cycle so no stale level survives
`default_nettype none
module ppu_pad_model #(
	parameter int W = 8
) (
	// clock
	input wire logic clk_i,
	// from the block
	input wire logic [W-1:0] pad_o,
	input wire logic [W-1:0] pad_oe_o,
	input wire logic [W-1:0] pull_o,
	// to the block
	output logic [W-1:0] pad_i
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [W-1:0] flt_q = '0; // floating level
	// floating pins wander
	always @(posedge clk_i) begin
		flt_q <= ~flt_q;
	end
	// driven pin follows the block, pulled input reads high
	assign pad_i = (pad_oe_o & pad_o) | (~pad_oe_o & (pull_o | flt_q));
endmodule : ppu_pad_model
`default_nettype wire

// File: ppu_pin_bank.sv
// Purpose: pad control for one port: drive, pullup gating and input filtering
// Assumes: pad inputs are asynchronous to clk_i
// Notes: a level change is taken once the second and third stages agree
`default_nettype none

module ppu_pin_bank
	import ppu_pkg::*;
#(
	parameter int W = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// configuration from the register file
	ppu_pin_if.pin cfg,
	// pads
	input wire logic [W-1:0] pad_i,
	output logic [W-1:0] pad_o,
	output logic [W-1:0] pad_oe_o,
	output logic [W-1:0] pull_o
);

	logic [W-1:0] s1_q; // first stage, read only by s2
	logic [W-1:0] s2_q; // second stage
	logic [W-1:0] s3_q; // third stage
	logic [W-1:0] lvl_q; // accepted level
	logic [W-1:0] is_input; // pin is an enabled input
	logic [W-1:0] agree; // stages two and three match

	// pullup only reaches a pin that is an enabled input
	assign is_input = ~cfg.dir & ~cfg.in_off;
	assign pull_o = cfg.pull_en & is_input;

	// drive only while the pin is an output
	assign pad_o = cfg.dout;
	assign pad_oe_o = cfg.dir;

	// a disabled input buffer reads as zero
	assign agree = ~(s2_q ^ s3_q);
	assign cfg.level = lvl_q & ~cfg.in_off;

	// three-stage synchroniser
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else if (ce_i) begin
			s1_q <= pad_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// accept each bit once two stages agree, filters single-cycle glitches
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lvl_q <= '0;
		end else if (ce_i) begin
			lvl_q <= (agree & s3_q) | (~agree & lvl_q);
		end
	end

endmodule : ppu_pin_bank

`default_nettype wire

// File: ppu_pin_if.sv
// Purpose: carries one port's configuration to its pin bank and its pin levels back
// Assumes: width set per port by the instantiating module
// Notes: ctl side is the register file, pin side is the pad logic
`default_nettype none

interface ppu_pin_if #(
	parameter int W = 8
);
	logic [W-1:0] dout; // value driven on output pins
	logic [W-1:0] dir; // 1 = output
	logic [W-1:0] in_off; // 1 = input buffer off (high impedance state)
	logic [W-1:0] pull_en; // software pullup enables
	logic [W-1:0] level; // filtered pin level

	modport ctl (
		output dout,
		output dir,
		output in_off,
		output pull_en,
		input level
	);
	modport pin (
		input dout,
		input dir,
		input in_off,
		input pull_en,
		output level
	);
endinterface : ppu_pin_if

`default_nettype wire

// File: ppu_pkg.sv
// Purpose: types shared by the pullup enable block
// Assumes: ppu_defines.svh gives every number
// Notes: only types live here
`default_nettype none

package ppu_pkg;

	// register selected by the current bus address
	typedef enum logic [3:0] {
		PPU_SEL_NONE,
		PPU_SEL_PE_PULL,
		PPU_SEL_PD_PULL,
		PPU_SEL_PE_DOUT,
		PPU_SEL_PE_DIR,
		PPU_SEL_PE_INOFF,
		PPU_SEL_PE_LEVEL,
		PPU_SEL_PD_DOUT,
		PPU_SEL_PD_DIR,
		PPU_SEL_PD_INOFF,
		PPU_SEL_PD_LEVEL
	} ppu_reg_sel_t;

endpackage : ppu_pkg

`default_nettype wire

// File: ppu_top.sv
// Purpose: pullup enable control for ports e and d behind a wishbone slave
// Assumes: classic wishbone, single clock, synchronous active-high reset
// Notes: one ack per request, given the cycle after stb is seen
// Contract
// - set bit turns pullup on, clear off
// - pullup acts only on input pins
// - port e pullup register at 30f4h, resets zero
// - reset leaves pins high-impedance inputs, pullups off
// - port e bit n controls pin n
// - port d bits 2..0 control pins 2..0
//
// Register access over Wishbone is this design's own decision.
`include "ppu_defines.svh"
`default_nettype none

module ppu_top
	import ppu_pkg::*;
(
	// clock, reset, clock enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [`PPU_ADR_W-1:0] adr_i,
	input wire logic [`PPU_SEL_W-1:0] sel_i,
	input wire logic [`PPU_DAT_W-1:0] dat_i,
	output logic [`PPU_DAT_W-1:0] dat_o,
	output logic ack_o,
	// port e pads
	input wire logic [`PPU_PE_W-1:0] pe_pad_i,
	output logic [`PPU_PE_W-1:0] pe_pad_o,
	output logic [`PPU_PE_W-1:0] pe_pad_oe_o,
	output logic [`PPU_PE_W-1:0] pe_pull_o,
	// port d pads
	input wire logic [`PPU_PD_W-1:0] pd_pad_i,
	output logic [`PPU_PD_W-1:0] pd_pad_o,
	output logic [`PPU_PD_W-1:0] pd_pad_oe_o,
	output logic [`PPU_PD_W-1:0] pd_pull_o
);

	// address compare on the word part, byte offset bits ignored
	function automatic logic adr_hit(
		input logic [`PPU_ADR_W-1:0] adr,
		input logic [`PPU_ADR_W-1:0] reg_adr
	);
		adr_hit = (adr[`PPU_ADR_W-1:2] == reg_adr[`PPU_ADR_W-1:2]);
	endfunction : adr_hit

	// byte-lane merge of an 8-bit register, untouched when lane 0 not strobed
	function automatic logic [`PPU_REG_W-1:0] lane_merge(
		input logic [`PPU_REG_W-1:0] old,
		input logic [`PPU_DAT_W-1:0] dat,
		input logic [`PPU_SEL_W-1:0] sel
	);
		lane_merge = sel[`PPU_DATA_LANE] ? dat[`PPU_REG_W-1:0] : old;
	endfunction : lane_merge

	// same merge for the three-bit port d words; lane bits 7:3 are dropped
	function automatic logic [`PPU_PD_W-1:0] lane_merge_pd(
		input logic [`PPU_PD_W-1:0] old,
		input logic [`PPU_DAT_W-1:0] dat,
		input logic [`PPU_SEL_W-1:0] sel
	);
		lane_merge_pd = sel[`PPU_DATA_LANE] ? dat[`PPU_PD_W-1:0] : old;
	endfunction : lane_merge_pd

	// zero-extend an 8-bit value onto the data bus
	function automatic logic [`PPU_DAT_W-1:0] widen(
		input logic [`PPU_REG_W-1:0] v
	);
		widen = {{(`PPU_DAT_W-`PPU_REG_W){1'b0}}, v};
	endfunction : widen

	// port e registers
	logic [`PPU_PE_W-1:0] pe_pull_q; // pullup enables
	logic [`PPU_PE_W-1:0] pe_dout_q; // output data
	logic [`PPU_PE_W-1:0] pe_dir_q; // 1 = output
	logic [`PPU_PE_W-1:0] pe_inoff_q; // 1 = input buffer off
	// port d registers
	logic [`PPU_PD_W-1:0] pd_pull_q; // pullup enables
	logic [`PPU_PD_W-1:0] pd_dout_q; // output data
	logic [`PPU_PD_W-1:0] pd_dir_q; // 1 = output
	logic [`PPU_PD_W-1:0] pd_inoff_q; // 1 = input buffer off
	// bus answer
	logic ack_q; // one-cycle acknowledge
	logic [`PPU_DAT_W-1:0] dat_q; // registered read data
	logic [`PPU_DAT_W-1:0] rd_d; // read data of the addressed word

	// request decode
	logic req; // new request, not the one just acked
	logic wr_en; // a write takes effect this edge
	ppu_reg_sel_t reg_sel; // addressed register

	// carriers to the pin banks
	ppu_pin_if #(.W(`PPU_PE_W)) pe_if ();
	ppu_pin_if #(.W(`PPU_PD_W)) pd_if ();

	// the register just acked is not taken again while the master releases
	assign req = cyc_i & stb_i & ~ack_q;
	assign wr_en = req & we_i & ce_i;

	// address decode; port e pullup word sits at its fixed address
	assign reg_sel =
		adr_hit(adr_i, `PPU_PE_PULL_ADR) ? PPU_SEL_PE_PULL :
		adr_hit(adr_i, `PPU_PD_PULL_ADR) ? PPU_SEL_PD_PULL :
		adr_hit(adr_i, `PPU_PE_DOUT_ADR) ? PPU_SEL_PE_DOUT :
		adr_hit(adr_i, `PPU_PE_DIR_ADR) ? PPU_SEL_PE_DIR :
		adr_hit(adr_i, `PPU_PE_INOFF_ADR) ? PPU_SEL_PE_INOFF :
		adr_hit(adr_i, `PPU_PE_LEVEL_ADR) ? PPU_SEL_PE_LEVEL :
		adr_hit(adr_i, `PPU_PD_DOUT_ADR) ? PPU_SEL_PD_DOUT :
		adr_hit(adr_i, `PPU_PD_DIR_ADR) ? PPU_SEL_PD_DIR :
		adr_hit(adr_i, `PPU_PD_INOFF_ADR) ? PPU_SEL_PD_INOFF :
		adr_hit(adr_i, `PPU_PD_LEVEL_ADR) ? PPU_SEL_PD_LEVEL :
		PPU_SEL_NONE;

	// read mux: stored values and filtered pin levels read back, unmapped words read zero
	always_comb begin
		case (reg_sel)
			PPU_SEL_PE_PULL: rd_d = widen(pe_pull_q);
			PPU_SEL_PD_PULL: rd_d = widen({5'h00, pd_pull_q});
			PPU_SEL_PE_DOUT: rd_d = widen(pe_dout_q);
			PPU_SEL_PE_DIR: rd_d = widen(pe_dir_q);
			PPU_SEL_PE_INOFF: rd_d = widen(pe_inoff_q);
			PPU_SEL_PE_LEVEL: rd_d = widen(pe_if.level);
			PPU_SEL_PD_DOUT: rd_d = widen({5'h00, pd_dout_q});
			PPU_SEL_PD_DIR: rd_d = widen({5'h00, pd_dir_q});
			PPU_SEL_PD_INOFF: rd_d = widen({5'h00, pd_inoff_q});
			PPU_SEL_PD_LEVEL: rd_d = widen({5'h00, pd_if.level});
			default: rd_d = '0;
		endcase
	end

	// acknowledge and read data, one cycle after the request is seen
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= '0;
		end else if (ce_i) begin
			ack_q <= req;
			// clear read data to zero outside an answer so the bus stays quiet
			if (req & ~we_i) begin
				dat_q <= rd_d;
			end else begin
				dat_q <= '0;
			end
		end
	end

	// port e pullup word, bit n belongs to pin n
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pe_pull_q <= `PPU_PE_RST;
		end else if (wr_en && reg_sel == PPU_SEL_PE_PULL) begin
			pe_pull_q <= lane_merge(pe_pull_q, dat_i, sel_i);
		end
	end

	// port d pullup word, only bits 2..0 are stored
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pd_pull_q <= `PPU_PD_RST;
		end else if (wr_en && reg_sel == PPU_SEL_PD_PULL) begin
			pd_pull_q <= lane_merge_pd(pd_pull_q, dat_i, sel_i);
		end
	end

	// port e pin configuration; reset leaves every pin an undriven input
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pe_dout_q <= `PPU_PE_RST;
			pe_dir_q <= `PPU_PE_RST;
			pe_inoff_q <= `PPU_PE_RST;
		end else if (wr_en) begin
			if (reg_sel == PPU_SEL_PE_DOUT) begin
				pe_dout_q <= lane_merge(pe_dout_q, dat_i, sel_i);
			end
			if (reg_sel == PPU_SEL_PE_DIR) begin
				pe_dir_q <= lane_merge(pe_dir_q, dat_i, sel_i);
			end
			if (reg_sel == PPU_SEL_PE_INOFF) begin
				pe_inoff_q <= lane_merge(pe_inoff_q, dat_i, sel_i);
			end
		end
	end

	// port d pin configuration, same layout in the low three bits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pd_dout_q <= `PPU_PD_RST;
			pd_dir_q <= `PPU_PD_RST;
			pd_inoff_q <= `PPU_PD_RST;
		end else if (wr_en) begin
			if (reg_sel == PPU_SEL_PD_DOUT) begin
				pd_dout_q <= lane_merge_pd(pd_dout_q, dat_i, sel_i);
			end
			if (reg_sel == PPU_SEL_PD_DIR) begin
				pd_dir_q <= lane_merge_pd(pd_dir_q, dat_i, sel_i);
			end
			if (reg_sel == PPU_SEL_PD_INOFF) begin
				pd_inoff_q <= lane_merge_pd(pd_inoff_q, dat_i, sel_i);
			end
		end
	end

	// configuration onto the carriers
	assign pe_if.dout = pe_dout_q;
	assign pe_if.dir = pe_dir_q;
	assign pe_if.in_off = pe_inoff_q;
	assign pe_if.pull_en = pe_pull_q;
	assign pd_if.dout = pd_dout_q;
	assign pd_if.dir = pd_dir_q;
	assign pd_if.in_off = pd_inoff_q;
	assign pd_if.pull_en = pd_pull_q;

	// bus outputs from flip-flops
	assign ack_o = ack_q;
	assign dat_o = dat_q;

	// port e pad logic; pullup gated by pin mode inside
	ppu_pin_bank #(.W(`PPU_PE_W)) u_pe_bank (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.cfg(pe_if.pin),
		.pad_i(pe_pad_i),
		.pad_o(pe_pad_o),
		.pad_oe_o(pe_pad_oe_o),
		.pull_o(pe_pull_o)
	);

	// port d pad logic
	ppu_pin_bank #(.W(`PPU_PD_W)) u_pd_bank (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.cfg(pd_if.pin),
		.pad_i(pd_pad_i),
		.pad_o(pd_pad_o),
		.pad_oe_o(pd_pad_oe_o),
		.pull_o(pd_pull_o)
	);

endmodule : ppu_top

`default_nettype wire

// File: ppu_top_props.sv
// Purpose: bus and pullup checks on the pullup enable block
// Assumes: ce_i held high; shadows track port e pullup and input-off registers
// Notes: bound to ppu_top below
`default_nettype none
module ppu_top_props (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [15:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	// pads
	input wire logic [7:0] pe_pad_oe_o,
	input wire logic [7:0] pe_pull_o,
	input wire logic [2:0] pd_pad_oe_o,
	input wire logic [2:0] pd_pull_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic take, wr_ok; // request taken, low lane written
	logic [7:0] pe_q, pe_d, off_q, off_d; // shadow pullups and input-off
	assign take = cyc_i && stb_i && !ack_o;
	assign wr_ok = take && we_i && sel_i[0];
	assign pe_d = (wr_ok && adr_i[15:2] == 14'h0c3d) ? dat_i[7:0] : pe_q;
	assign off_d = (wr_ok && adr_i[15:2] == 14'h0c3a) ? dat_i[7:0] : off_q;
	// shadows clear with the block
	always_ff @(posedge clk_i) begin
		pe_q <= rst_i ? 8'h00 : pe_d;
		off_q <= rst_i ? 8'h00 : off_d;
	end
	AST_ACK_NEXT: assert property (take |=> ack_o) else $error("ack missing");
	AST_ACK_CAUSE: assert property (!take |=> !ack_o) else $error("stray ack");
	AST_DAT_IDLE: assert property (!(ack_o && !we_i) |-> dat_o == 32'h0)
		else $error("read data outside read");
	AST_RD_PE: assert property (ack_o && !we_i && adr_i[15:2] == 14'h0c3d |->
		dat_o == {24'h0, pe_q}) else $error("port e pullup readback");
	AST_RD_PD: assert property (ack_o && !we_i && adr_i[15:2] == 14'h0c3c |->
		dat_o[31:3] == 29'h0) else $error("port d upper bits");
	AST_PE_PULL: assert property (pe_pull_o == (pe_q & ~pe_pad_oe_o & ~off_q))
		else $error("port e pullup gating");
	AST_PD_OUT: assert property ((pd_pull_o & pd_pad_oe_o) == 3'h0)
		else $error("pullup on output");
	AST_RST: assert property ($fell(rst_i) |-> !ack_o && pe_pull_o == 8'h00 &&
		pd_pull_o == 3'h0 && pe_pad_oe_o == 8'h00 && pd_pad_oe_o == 3'h0)
		else $error("reset state");
	COV_WR: cover property (wr_ok && adr_i == 16'h30f4);
	COV_RD: cover property (ack_o && !we_i && adr_i == 16'h30f4);
	COV_PULL: cover property (pe_pull_o != 8'h00);
endmodule : ppu_top_props
bind ppu_top ppu_top_props u_props (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
	.sel_i, .dat_i, .dat_o, .ack_o, .pe_pad_oe_o, .pe_pull_o, .pd_pad_oe_o, .pd_pull_o);
`default_nettype wire

// File: test_port_pullup_enable_control.sv
// Purpose: self-checking bench for the pullup enable block
// Assumes: ce_i held high; pads come from the board model
// Notes: random register traffic compared with a model after every access
`default_nettype none
module test_port_pullup_enable_control;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [15:0] adr_i = 16'h0;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0, dat_o, q, rs = 32'h0ad8; // rs: xorshift state
	logic ack_o;
	logic [7:0] pe_pad_i, pe_pad_o, pe_oe, pe_pull;
	logic [2:0] pd_pad_i, pd_pad_o, pd_oe, pd_pull;
	int err_total = 0, num_checks = 0, cyc_n = 0;
	int m[8]; // model registers, last slot of adrs is unmapped
	logic [15:0] adrs[9] = '{16'h30f4, 16'h30f0, 16'h30e0, 16'h30e4, 16'h30e8,
		16'h30d0, 16'h30d4, 16'h30d8, 16'h3100};
	always #50 clk_i = ~clk_i;
	ppu_top DUT (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
		.dat_o, .ack_o, .pe_pad_i, .pe_pad_o, .pe_pad_oe_o(pe_oe), .pe_pull_o(pe_pull),
		.pd_pad_i, .pd_pad_o, .pd_pad_oe_o(pd_oe), .pd_pull_o(pd_pull));
	ppu_pad_model #(.W(8)) u_pe (.clk_i, .pad_o(pe_pad_o), .pad_oe_o(pe_oe),
		.pull_o(pe_pull), .pad_i(pe_pad_i));
	ppu_pad_model #(.W(3)) u_pd (.clk_i, .pad_o(pd_pad_o), .pad_oe_o(pd_oe),
		.pull_o(pd_pull), .pad_i(pd_pad_i));
	function automatic logic [31:0] nxt();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : nxt
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic complete_run();
		if (err_total == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : complete_run
	task automatic do_reset();
		rst_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		m = '{default: 0};
	endtask : do_reset
	// one classic cycle, model update, then pin comparison
	task automatic op(input logic w, input int i, input logic [31:0] d, input logic [3:0] s);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= adrs[i];
		dat_i <= d;
		sel_i <= s;
		// wait for the answer; only the hang guard ends a lost request
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
		if (w && i < 8 && s[0]) m[i] = d[7:0] & ((i == 1 || i >= 5) ? 32'h7 : 32'hff);
		if (!w) chk(q, (i < 8) ? m[i] : 32'h0);
		chk(pe_pull, m[0] & ~m[3] & ~m[4] & 32'hff);
		chk(pd_pull, m[1] & ~m[6] & ~m[7] & 32'h7);
		chk({pd_oe, pe_oe}, (m[6] << 8) | m[3]);
		chk({pd_pad_o, pe_pad_o}, (m[5] << 8) | m[2]);
	endtask : op
	initial begin
		do_reset();
		for (int i = 0; i < 9; i++) op(1'b0, i, 32'h0, 4'hf);
		for (int b = 0; b < 8; b++) op(1'b1, 0, 32'h1 << b, 4'h1);
		for (int k = 0; k < 300; k++) begin
			logic [31:0] r;
			r = nxt();
			op(r[4], r[8:5] % 9, nxt(), r[12:9]);
		end
		do_reset();
		for (int i = 0; i < 9; i++) op(1'b0, i, 32'h0, 4'hf);
		complete_run();
	end
	// hang guard
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n > 5000) begin
			err_total++;
			$display("[ERR] %0t timeout", $time);
			complete_run();
		end
	end
endmodule : test_port_pullup_enable_control
`default_nettype wire
